// *** core/agrb_pkg.sv ***
// package: register map, field layout and probe formats of the gain readback/test/probe bank
package agrb_pkg;

  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 8;
  localparam int TEST_W   = 14;
  localparam int PROBE_W  = 20;
  localparam int LEVEL_W  = 8;
  localparam int NCO_COS_W = 17;
  localparam int NCO_RND_W = 15;
  localparam int CIC_W    = 9;

  localparam logic [4:0] ADDR_LEVEL_A  = 5'h19;
  localparam logic [4:0] ADDR_LEVEL_B  = 5'h1A;
  localparam logic [4:0] ADDR_TEST_LO  = 5'h1B;
  localparam logic [4:0] ADDR_TEST_HI  = 5'h1C;
  localparam logic [4:0] ADDR_SPARE_1  = 5'h1D;
  localparam logic [4:0] ADDR_SPARE_2  = 5'h1E;
  localparam logic [4:0] ADDR_PROBE    = 5'h1F;

  localparam int TEST_HI_W      = 6;
  localparam int PROBE_EN_BIT   = 0;
  localparam int PROBE_SEL_LSB  = 1;
  localparam int PROBE_SEL_W    = 5;

  localparam logic [7:0] TEST_LO_RST  = 8'h00;
  localparam logic [5:0] TEST_HI_RST  = 6'h00;
  localparam logic [5:0] PROBE_RST    = 6'h00;

  // selector code groups
  localparam logic [4:0] SEL_FIR_LAST = 5'h07;
  localparam logic [4:0] SEL_COS_LAST = 5'h0B;
  localparam logic [4:0] SEL_RND_LAST = 5'h0F;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } agrb_req_t;

  typedef struct packed {
    logic [PROBE_W-1:0] fir_in_a0;
    logic [PROBE_W-1:0] fir_in_a1;
    logic [PROBE_W-1:0] fir_in_b0;
    logic [PROBE_W-1:0] fir_in_b1;
    logic [PROBE_W-1:0] fir_out_a0;
    logic [PROBE_W-1:0] fir_out_a1;
    logic [PROBE_W-1:0] fir_out_b0;
    logic [PROBE_W-1:0] fir_out_b1;
    logic [NCO_COS_W-1:0] nco_cos_a0;
    logic [NCO_COS_W-1:0] nco_cos_a1;
    logic [NCO_COS_W-1:0] nco_cos_b0;
    logic [NCO_COS_W-1:0] nco_cos_b1;
    logic [NCO_RND_W-1:0] nco_rnd_a0;
    logic [NCO_RND_W-1:0] nco_rnd_a1;
    logic [NCO_RND_W-1:0] nco_rnd_b0;
    logic [NCO_RND_W-1:0] nco_rnd_b1;
    logic [CIC_W-1:0]     cic_a;
    logic [CIC_W-1:0]     cic_b;
  } agrb_taps_t;

endpackage

// *** core/agrb_sync.sv ***
// two flip-flop synchroniser for a pin bus
module agrb_sync #(
  parameter int W = 14
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         reset_n_i,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // a zero-width bus has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("agrb_sync: W must be at least 1");
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// *** core/agrb_probe_mux.sv ***
// probe selector: formats the chosen internal node into the 20-bit probe word
module agrb_probe_mux
  import agrb_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  // control
  input  wire logic                     enable_i,
  input  wire logic [PROBE_SEL_W-1:0]   select_i,
  input  wire agrb_pkg::agrb_taps_t     taps_i,
  // probe word
  output logic      [PROBE_W-1:0]       probe_o
);
  import agrb_pkg::*;

  logic [PROBE_W-1:0] fir_tab [8];
  logic [NCO_COS_W-1:0] cos_tab [4];
  logic [NCO_RND_W-1:0] rnd_tab [4];
  logic [PROBE_W-1:0] pick;
  logic [PROBE_W-1:0] probe_q;

  assign fir_tab[0] = taps_i.fir_out_b0;
  assign fir_tab[1] = taps_i.fir_out_b1;
  assign fir_tab[2] = taps_i.fir_out_a0;
  assign fir_tab[3] = taps_i.fir_out_a1;
  assign fir_tab[4] = taps_i.fir_in_b0;
  assign fir_tab[5] = taps_i.fir_in_b1;
  assign fir_tab[6] = taps_i.fir_in_a0;
  assign fir_tab[7] = taps_i.fir_in_a1;
  assign cos_tab[0] = taps_i.nco_cos_a0;
  assign cos_tab[1] = taps_i.nco_cos_a1;
  assign cos_tab[2] = taps_i.nco_cos_b0;
  assign cos_tab[3] = taps_i.nco_cos_b1;
  assign rnd_tab[0] = taps_i.nco_rnd_a0;
  assign rnd_tab[1] = taps_i.nco_rnd_a1;
  assign rnd_tab[2] = taps_i.nco_rnd_b0;
  assign rnd_tab[3] = taps_i.nco_rnd_b1;

  wire is_cic = select_i[4];
  wire is_fir = !is_cic && (select_i <= SEL_FIR_LAST);
  wire is_cos = !is_cic && !is_fir && (select_i <= SEL_COS_LAST);
  wire [PROBE_W-1:0] fir_word = fir_tab[select_i[2:0]];
  wire [PROBE_W-1:0] cos_word = {cos_tab[select_i[1:0]], 3'h0};
  wire [PROBE_W-1:0] rnd_word = {rnd_tab[select_i[1:0]], 5'h00};
  wire [PROBE_W-1:0] cic_word = {taps_i.cic_a, taps_i.cic_b, 2'h0};

  assign pick = is_cic ? cic_word :
                is_fir ? fir_word :
                is_cos ? cos_word : rnd_word;

  // probe sits at zero while disabled so no internal node leaks out
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      probe_q <= '0;
    end else begin
      probe_q <= enable_i ? pick : '0;
    end
  end

  assign probe_o = probe_q;
endmodule

// *** core/agrb_regs.sv ***
// gain-loop readback, test input word and probe control register bank
//
// Function
// - read A returns channel A integrator MSBs
// - read B returns channel B integrator MSBs
// - test mode replaces both pin sample buses
// - test word low 27, high 28
// - address 31 bit 0 enables probe
// - bits 5:1 of 31 select probe node
// - low codes route FIR one taps
// - NCO cosine tap, 17 bits, 3 zeros
// - NCO rounded tap, 15 bits, 5 zeros
// - codes 16-31 route gain CIC output
//
// Implementation choice: strobed register access.
module agrb_regs
  import agrb_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_n_i,
  // register port
  input  wire agrb_pkg::agrb_req_t    req_i,
  output logic [agrb_pkg::DATA_W-1:0] rdata_o,
  // gain loop integrator levels
  input  wire logic [agrb_pkg::LEVEL_W-1:0] gain_loop_level_a_i,
  input  wire logic [agrb_pkg::LEVEL_W-1:0] gain_loop_level_b_i,
  // sample path
  input  wire logic                   test_source_sel_i,
  input  wire logic [agrb_pkg::TEST_W-1:0] channel_a_sample_bus_i,
  input  wire logic [agrb_pkg::TEST_W-1:0] channel_b_sample_bus_i,
  output logic [agrb_pkg::TEST_W-1:0] channel_a_samples_o,
  output logic [agrb_pkg::TEST_W-1:0] channel_b_samples_o,
  // probe
  input  wire agrb_pkg::agrb_taps_t   taps_i,
  output logic                        probe_enable_o,
  output logic [agrb_pkg::PROBE_W-1:0] probe_o
);
  import agrb_pkg::*;

  logic [7:0]           test_lo_q;
  logic [TEST_HI_W-1:0] test_hi_q;
  logic [5:0]           probe_ctl_q;
  logic [DATA_W-1:0]    rdata_q;
  logic [1:0]           test_sel_s;
  wire  [TEST_W-1:0]    pin_bus [2];

  assign pin_bus[0] = channel_a_sample_bus_i;
  assign pin_bus[1] = channel_b_sample_bus_i;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      test_sel_s <= 2'h0;
    end else begin
      test_sel_s <= {test_sel_s[0], test_source_sel_i};
    end
  end

  // write decode; spare addresses have no storage behind them
  wire wr_lo    = req_i.wr && (req_i.addr == ADDR_TEST_LO);
  wire wr_hi    = req_i.wr && (req_i.addr == ADDR_TEST_HI);
  wire wr_probe = req_i.wr && (req_i.addr == ADDR_PROBE);

  wire [TEST_W-1:0] test_word = {test_hi_q, test_lo_q};
  wire              test_on   = test_sel_s[1];

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    if (req_i.addr == ADDR_LEVEL_A) begin
      rd_mux = gain_loop_level_a_i;
    end else if (req_i.addr == ADDR_LEVEL_B) begin
      rd_mux = gain_loop_level_b_i;
    end else if (req_i.addr == ADDR_TEST_LO) begin
      rd_mux = test_lo_q;
    end else if (req_i.addr == ADDR_TEST_HI) begin
      rd_mux = {2'h0, test_hi_q};
    end else if (req_i.addr == ADDR_PROBE) begin
      rd_mux = {2'h0, probe_ctl_q};
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      test_lo_q   <= TEST_LO_RST;
      test_hi_q   <= TEST_HI_RST;
      probe_ctl_q <= PROBE_RST;
    end else begin
      if (wr_lo) test_lo_q <= req_i.wdata;
      if (wr_hi) test_hi_q <= req_i.wdata[TEST_HI_W-1:0];
      if (wr_probe) probe_ctl_q <= req_i.wdata[5:0];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= req_i.rd ? rd_mux : 8'h00;
    end
  end

  // pin buses arrive from the converters, outside this clock's timing
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [TEST_W-1:0] pin_s;
    logic [TEST_W-1:0] samp_q;

    agrb_sync #(.W(TEST_W)) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (pin_bus[ch]),
      .sync_o    (pin_s)
    );

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        samp_q <= '0;
      end else begin
        samp_q <= test_on ? test_word : pin_s;
      end
    end
  end

  agrb_probe_mux u_probe (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .enable_i  (probe_ctl_q[PROBE_EN_BIT]),
    .select_i  (probe_ctl_q[PROBE_SEL_LSB +: PROBE_SEL_W]),
    .taps_i    (taps_i),
    .probe_o   (probe_o)
  );

  logic probe_en_q;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      probe_en_q <= 1'b0;
    end else begin
      probe_en_q <= probe_ctl_q[PROBE_EN_BIT];
    end
  end

  assign rdata_o             = rdata_q;
  assign channel_a_samples_o = g_chan[0].samp_q;
  assign channel_b_samples_o = g_chan[1].samp_q;
  assign probe_enable_o      = probe_en_q;
endmodule

// *** verification/agrb_regs_asserts.sv ***
// checker: port-level timing and value relations of the gain readback bank
module agrb_regs_asserts
  import agrb_pkg::*;
(
  // clock and reset
  input wire logic                  ref_clk_i,
  input wire logic                  reset_n_i,
  // register port and levels
  input wire agrb_pkg::agrb_req_t   req_i,
  input wire logic [7:0]            rdata_o,
  input wire logic [7:0]            gain_loop_level_a_i,
  input wire logic [7:0]            gain_loop_level_b_i,
  // sample path and probe
  input wire logic                  test_source_sel_i,
  input wire logic [13:0]           channel_a_samples_o,
  input wire logic [13:0]           channel_b_samples_o,
  input wire agrb_pkg::agrb_taps_t  taps_i,
  input wire logic                  probe_enable_o,
  input wire logic [19:0]           probe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  ctl_q;
  logic [13:0] word_q;
  wire         rd_a = req_i.rd && req_i.addr == ADDR_LEVEL_A;
  wire         rd_b = req_i.rd && req_i.addr == ADDR_LEVEL_B;
  wire         rd_s = req_i.rd && (req_i.addr == ADDR_SPARE_1 || req_i.addr == ADDR_SPARE_2);
  wire         wr_p = req_i.wr && req_i.addr == ADDR_PROBE;
  // shadow of the writable fields, so probe and test path can be predicted
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_q  <= 6'h00;
      word_q <= 14'h0000;
    end else if (req_i.wr) begin
      if (req_i.addr == ADDR_PROBE) ctl_q <= req_i.wdata[5:0];
      if (req_i.addr == ADDR_TEST_LO) word_q[7:0] <= req_i.wdata;
      if (req_i.addr == ADDR_TEST_HI) word_q[13:8] <= req_i.wdata[5:0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_read_a; rd_a |=> rdata_o == $past(gain_loop_level_a_i); endproperty
  a_read_a: assert property (p_read_a) else $error("level A readback wrong");
  property p_read_b; rd_b |=> rdata_o == $past(gain_loop_level_b_i); endproperty
  a_read_b: assert property (p_read_b) else $error("level B readback wrong");
  property p_spare; rd_s |=> rdata_o == 8'h00; endproperty
  a_spare: assert property (p_spare) else $error("spare byte not zero");
  property p_test; (test_source_sel_i && !req_i.wr) [*5] |->
    channel_a_samples_o == word_q && channel_b_samples_o == word_q; endproperty
  a_test: assert property (p_test) else $error("test word not on sample path");
  property p_en; wr_p |-> ##2 probe_enable_o == $past(req_i.wdata[0], 2); endproperty
  a_en: assert property (p_en) else $error("probe enable wrong");
  property p_off; !probe_enable_o |-> probe_o == 20'h00000; endproperty
  a_off: assert property (p_off) else $error("probe active while disabled");
  property p_cic; ctl_q[0] && ctl_q[5] |=>
    probe_o == {$past(taps_i.cic_a), $past(taps_i.cic_b), 2'h0}; endproperty
  a_cic: assert property (p_cic) else $error("cic probe format wrong");
  property p_cos; ctl_q[0] && ctl_q[5:3] == 3'h2 |=> probe_o[2:0] == 3'h0; endproperty
  a_cos: assert property (p_cos) else $error("cosine probe low bits set");
  property p_rnd; ctl_q[0] && ctl_q[5:3] == 3'h3 |=> probe_o[4:0] == 5'h00; endproperty
  a_rnd: assert property (p_rnd) else $error("rounded probe low bits set");
  c_read: cover property (rd_a ##[1:4] rd_b);
  c_test: cover property (test_source_sel_i [*6]);
  c_cic: cover property (ctl_q[0] && ctl_q[5]);
endmodule

// *** verification/agrb_regs_bench.sv ***
// bench: register port, sample path and probe selector of the gain readback bank
module agrb_regs_bench;
  import agrb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  agrb_req_t    req = '0;
  logic [7:0]   lvl_a = 8'hA5;
  logic [7:0]   lvl_b = 8'h5A;
  logic         sel = 1'b0;
  logic [13:0]  pin_a = 14'h1234;
  logic [13:0]  pin_b = 14'h2ACE;
  logic [319:0] pat = {10{32'h9E37_79B5}};
  agrb_taps_t   tp;
  logic [7:0]   rdata;
  logic [13:0]  sa;
  logic [13:0]  sb;
  logic         pen;
  logic [19:0]  probe;
  int           bad_count = 0;
  int           checks = 0;
  assign tp = pat[$bits(agrb_taps_t)-1:0];
  always #2.5 clk = ~clk;
  agrb_regs dut (.ref_clk_i(clk), .reset_n_i(rst_n), .req_i(req), .rdata_o(rdata),
    .gain_loop_level_a_i(lvl_a), .gain_loop_level_b_i(lvl_b), .test_source_sel_i(sel),
    .channel_a_sample_bus_i(pin_a), .channel_b_sample_bus_i(pin_b),
    .channel_a_samples_o(sa), .channel_b_samples_o(sb), .taps_i(tp),
    .probe_enable_o(pen), .probe_o(probe));
  function automatic logic [19:0] expect_probe(input logic [4:0] c);
    logic [19:0] f [8];
    logic [16:0] k [4];
    logic [14:0] r [4];
    f = '{tp.fir_out_b0, tp.fir_out_b1, tp.fir_out_a0, tp.fir_out_a1,
          tp.fir_in_b0, tp.fir_in_b1, tp.fir_in_a0, tp.fir_in_a1};
    k = '{tp.nco_cos_a0, tp.nco_cos_a1, tp.nco_cos_b0, tp.nco_cos_b1};
    r = '{tp.nco_rnd_a0, tp.nco_rnd_a1, tp.nco_rnd_b0, tp.nco_rnd_b1};
    if (c[4]) return {tp.cic_a, tp.cic_b, 2'h0};
    if (c[3:2] == 2'h2) return {k[c[1:0]], 3'h0};
    if (c[3:2] == 2'h3) return {r[c[1:0]], 5'h00};
    return f[c[2:0]];
  endfunction
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  // read data stands only in the cycle after the strobe, so look there
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    check(20'(rdata), 20'(e));
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_TEST_LO, 8'h00);
    rd(ADDR_TEST_HI, 8'h00);
    rd(ADDR_PROBE, 8'h00);
    rd(ADDR_LEVEL_A, 8'hA5);
    @(posedge clk);
    lvl_a <= 8'h3C;
    rd(ADDR_LEVEL_B, 8'h5A);
    rd(ADDR_LEVEL_A, 8'h3C);
    wr(ADDR_LEVEL_A, 8'hFF);
    wr(ADDR_SPARE_1, 8'hFF);
    wr(ADDR_SPARE_2, 8'hFF);
    rd(ADDR_LEVEL_A, 8'h3C);
    rd(ADDR_SPARE_1, 8'h00);
    rd(ADDR_SPARE_2, 8'h00);
    rd(5'h00, 8'h00);
    wr(ADDR_TEST_LO, 8'hC3);
    wr(ADDR_TEST_HI, 8'hFF);
    rd(ADDR_TEST_HI, 8'h3F);
    rd(ADDR_TEST_LO, 8'hC3);
    @(posedge clk);
    sel <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(20'(sa), 20'h03FC3);
    check(20'(sb), 20'h03FC3);
    @(posedge clk);
    sel <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(20'(sa), 20'(pin_a));
    check(20'(sb), 20'(pin_b));
    for (int c = 0; c < 32; c++) begin
      wr(ADDR_PROBE, {2'h0, c[4:0], 1'b1});
      repeat (2) @(posedge clk);
      #1;
      check(probe, expect_probe(c[4:0]));
      check(20'(pen), 20'h00001);
    end
    wr(ADDR_PROBE, 8'h3E);
    repeat (2) @(posedge clk);
    #1;
    check(probe, 20'h00000);
    check(20'(pen), 20'h00000);
    rd(ADDR_PROBE, 8'h3E);
    stop_test();
  end
endmodule
bind agrb_regs agrb_regs_asserts u_chk (.ref_clk_i, .reset_n_i, .req_i, .rdata_o,
  .gain_loop_level_a_i, .gain_loop_level_b_i, .test_source_sel_i, .channel_a_samples_o,
  .channel_b_samples_o, .taps_i, .probe_enable_o, .probe_o);
